// file: include/qwsd_pkg.sv
package qwsd_pkg;

    // ****************************************
    // word layout and sizes
    // ****************************************
    localparam int WORD_BITS   = 16;
    localparam int WIPER_BITS  = 6;
    localparam int NV_BITS     = 8;
    localparam int NV_DEPTH    = 16;
    localparam int WIPER_COUNT = 4;
    localparam int SYNC_DEPTH  = 2;

    typedef struct packed {
        logic [3:0] instr;
        logic [3:0] addr;
        logic [7:0] data;
    } qwsd_word_s;

    // ****************************************
    // instruction codes
    // ****************************************
    localparam logic [3:0] INST_NOP       = 4'h0;
    localparam logic [3:0] INST_RESTORE   = 4'h1;
    localparam logic [3:0] INST_SAVE      = 4'h2;
    localparam logic [3:0] INST_NV_WRITE  = 4'h3;
    localparam logic [3:0] INST_SHR_ONE   = 4'h4;
    localparam logic [3:0] INST_SHR_ALL   = 4'h5;
    localparam logic [3:0] INST_DEC_ONE   = 4'h6;
    localparam logic [3:0] INST_DEC_ALL   = 4'h7;
    localparam logic [3:0] INST_RELOAD    = 4'h8;
    localparam logic [3:0] INST_NV_READ   = 4'h9;
    localparam logic [3:0] INST_WIPER_RD  = 4'hA;
    localparam logic [3:0] INST_WIPER_WR  = 4'hB;
    localparam logic [3:0] INST_SHL_ONE   = 4'hC;
    localparam logic [3:0] INST_SHL_ALL   = 4'hD;
    localparam logic [3:0] INST_INC_ONE   = 4'hE;
    localparam logic [3:0] INST_INC_ALL   = 4'hF;

    // ****************************************
    // nonvolatile map and reset contents
    // ****************************************
    localparam logic [3:0] NV_ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] NV_ADDR_LATCH  = 4'h4;
    localparam logic [7:0] NV_INIT_WIPER  = 8'h20;
    localparam logic [7:0] NV_INIT_LATCH  = 8'h03;
    localparam logic [7:0] NV_INIT_USER   = 8'h00;
    localparam int         LATCH_ONE_BIT  = 0;
    localparam int         LATCH_TWO_BIT  = 1;
    localparam logic [5:0] WIPER_FULL     = 6'h3F;
    localparam logic [5:0] WIPER_MID      = 6'h20;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXEC,
        ST_NV_ADDR,
        ST_NV_DATA
    } qwsd_state_e;

    function automatic logic [7:0] qwsd_nv_init(input int idx);
        if (idx < WIPER_COUNT) begin
            return NV_INIT_WIPER;
        end
        if (idx == int'(NV_ADDR_LATCH)) begin
            return NV_INIT_LATCH;
        end
        return NV_INIT_USER;
    endfunction

endpackage

// file: rtl/qwsd_decoder.sv
module qwsd_decoder
    import qwsd_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  sclk,
    input  wire logic                  csN,
    input  wire logic                  serialIn,
    output logic                       serialOut,
    output logic                       serialOutOe,
    output logic [WIPER_COUNT-1:0][5:0] wiperPos,
    output logic                       latchedOutOne,
    output logic                       latchedOutTwo,
    output logic                       readPower,
    output logic                       busy
);

    initial begin
        if (SYNC_STAGES < 2) begin
            $error("synchroniser needs at least two stages");
        end
    end

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [5:0] wiperStep(input logic [3:0] op,
                                             input logic [5:0] v);
        logic [5:0] r;
        r = v;
        case (op)
            INST_SHR_ONE, INST_SHR_ALL: begin
                r = {1'b0, v[5:1]};
            end
            INST_DEC_ONE, INST_DEC_ALL: begin
                r = (v == 6'h00) ? 6'h00 : v - 6'h01;
            end
            INST_SHL_ONE, INST_SHL_ALL: begin
                if (v == 6'h00) begin
                    r = 6'h01;
                end else if (v >= WIPER_MID) begin
                    r = WIPER_FULL;
                end else begin
                    r = {v[4:0], 1'b0};
                end
            end
            INST_INC_ONE, INST_INC_ALL: begin
                r = (v == WIPER_FULL) ? WIPER_FULL : v + 6'h01;
            end
            default: begin
                r = v;
            end
        endcase
        return r;
    endfunction

    function automatic logic isAllOp(input logic [3:0] op);
        return op == INST_SHR_ALL || op == INST_DEC_ALL ||
               op == INST_SHL_ALL || op == INST_INC_ALL;
    endfunction

    function automatic logic isStepOp(input logic [3:0] op);
        return isAllOp(op) || op == INST_SHR_ONE || op == INST_DEC_ONE ||
               op == INST_SHL_ONE || op == INST_INC_ONE;
    endfunction

    // ****************************************
    // link side
    // ****************************************
    qwsd_word_s frameWord;
    logic       frameToggle;
    qwsd_word_s read_reg;
    logic       readValid_reg;

    qwsd_link u_link (
        .sclk        (sclk),
        .rst         (rst),
        .csN         (csN),
        .serialIn    (serialIn),
        .readWord    (read_reg),
        .readValid   (readValid_reg),
        .frameWord   (frameWord),
        .frameToggle (frameToggle),
        .serialOut   (serialOut),
        .serialOutOe (serialOutOe)
    );

    // ****************************************
    // crossings into clk
    // ****************************************
    logic [SYNC_STAGES-1:0] csSync_reg;
    logic [SYNC_STAGES-1:0] togSync_reg;
    logic                   csSeen_reg;
    logic                   togSeen_reg;
    wire                    csHigh   = csSync_reg[SYNC_STAGES-1];
    wire                    togNow   = togSync_reg[SYNC_STAGES-1];
    wire                    csRise   = csHigh && !csSeen_reg;
    wire                    newBits  = togNow != togSeen_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csSync_reg  <= '1;
            togSync_reg <= '0;
            csSeen_reg  <= 1'b1;
            togSeen_reg <= 1'b0;
        end else begin
            csSync_reg  <= {csSync_reg[SYNC_STAGES-2:0], csN};
            togSync_reg <= {togSync_reg[SYNC_STAGES-2:0], frameToggle};
            csSeen_reg  <= csHigh;
            if (csRise) begin
                togSeen_reg <= togNow;
            end
        end
    end

    // ****************************************
    // state and next values
    // ****************************************
    qwsd_state_e state_reg, state_next;
    qwsd_word_s  cmd_reg, cmd_next;
    qwsd_word_s  repeat_reg, repeat_next;
    logic        repeatValid_reg, repeatValid_next;
    qwsd_word_s  read_next;
    logic        readValid_next;
    logic [3:0]  idx_reg, idx_next;
    logic [3:0]  last_reg, last_next;
    logic [WIPER_COUNT-1:0][5:0] wiper_reg, wiper_next;
    logic [1:0]  latch_reg, latch_next;
    logic        readPower_reg, readPower_next;

    logic [3:0] nvAddr;
    logic       nvWe;
    logic [7:0] nvWData;
    logic [7:0] nvRData;

    qwsd_nv_store u_nv (
        .clk       (clk),
        .rst       (rst),
        .addr      (nvAddr),
        .writeEn   (nvWe),
        .writeData (nvWData),
        .readData  (nvRData)
    );

    // ****************************************
    // decode
    // ****************************************
    wire [3:0] op      = cmd_reg.instr;
    wire [1:0] wSel    = cmd_reg.addr[1:0];
    wire       allOp   = isAllOp(op);
    wire [5:0] wCur    = wiper_reg[wSel];
    wire       isLoad  = op == INST_RESTORE || op == INST_RELOAD ||
                         op == INST_NV_READ;
    wire [3:0] loadFirst = (op == INST_RELOAD) ? NV_ADDR_WIPER0 :
                           (op == INST_NV_READ) ? cmd_reg.addr :
                           {2'b00, wSel};
    wire [3:0] loadLast  = (op == INST_NV_READ) ? cmd_reg.addr : NV_ADDR_LATCH;
    // restore jumps from its one wiper straight to the latch byte
    wire [3:0] idxStep   = (op == INST_RESTORE) ? NV_ADDR_LATCH :
                           idx_reg + 4'h1;

    // save targets the wiper's own nv byte, whatever the upper address bits hold
    assign nvAddr  = (state_reg != ST_EXEC) ? idx_reg :
                     (op == INST_SAVE) ? {2'b00, wSel} : cmd_reg.addr;
    assign nvWe    = state_reg == ST_EXEC &&
                     (op == INST_SAVE || op == INST_NV_WRITE);
    assign nvWData = (op == INST_SAVE) ? {2'b00, wCur} :
                     cmd_reg.data;

    always_comb begin
        state_next       = state_reg;
        cmd_next         = cmd_reg;
        repeat_next      = repeat_reg;
        repeatValid_next = repeatValid_reg;
        read_next        = read_reg;
        readValid_next   = readValid_reg;
        idx_next         = idx_reg;
        last_next        = last_reg;
        wiper_next       = wiper_reg;
        latch_next       = latch_reg;
        readPower_next   = readPower_reg;
        case (state_reg)
            ST_IDLE: begin
                if (csRise) begin
                    if (newBits) begin
                        // readback word has been shifted out by now
                        readValid_next = 1'b0;
                        cmd_next       = frameWord;
                        state_next     = ST_EXEC;
                    end else if (repeatValid_reg) begin
                        cmd_next   = repeat_reg;
                        state_next = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
                if (isStepOp(op)) begin
                    repeat_next      = cmd_reg;
                    repeatValid_next = 1'b1;
                end else begin
                    repeatValid_next = 1'b0;
                end
                if (isStepOp(op)) begin
                    for (int i = 0; i < WIPER_COUNT; i++) begin
                        if (allOp || wSel == 2'(i)) begin
                            wiper_next[i] = wiperStep(op, wiper_reg[i]);
                        end
                    end
                end
                case (op)
                    INST_NOP: begin
                        readPower_next = 1'b0;
                    end
                    INST_RESTORE: begin
                        readPower_next = 1'b1;
                    end
                    INST_WIPER_WR: begin
                        wiper_next[wSel] = cmd_reg.data[5:0];
                    end
                    INST_WIPER_RD: begin
                        read_next      = {cmd_reg.instr, cmd_reg.addr,
                                          2'b00, wCur};
                        readValid_next = 1'b1;
                    end
                    default: begin
                    end
                endcase
                if (isLoad) begin
                    idx_next   = loadFirst;
                    last_next  = loadLast;
                    state_next = ST_NV_ADDR;
                end
            end
            ST_NV_ADDR: begin
                state_next = ST_NV_DATA;
            end
            ST_NV_DATA: begin
                if (op == INST_NV_READ) begin
                    read_next      = {cmd_reg.instr, cmd_reg.addr,
                                      nvRData};
                    readValid_next = 1'b1;
                end else if (idx_reg == NV_ADDR_LATCH) begin
                    latch_next = nvRData[1:0];
                end else begin
                    wiper_next[idx_reg[1:0]] = nvRData[5:0];
                end
                if (idx_reg == last_reg) begin
                    state_next = ST_IDLE;
                end else begin
                    idx_next   = idxStep;
                    state_next = ST_NV_ADDR;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    // reset starts a reload of every wiper and the latch byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg       <= ST_NV_ADDR;
            cmd_reg         <= {INST_RELOAD, 4'h0, 8'h00};
            idx_reg         <= NV_ADDR_WIPER0;
            last_reg        <= NV_ADDR_LATCH;
            repeat_reg      <= '0;
            repeatValid_reg <= 1'b0;
            read_reg        <= '0;
            readValid_reg   <= 1'b0;
            wiper_reg       <= '0;
            latch_reg       <= NV_INIT_LATCH[1:0];
            readPower_reg   <= 1'b0;
        end else begin
            state_reg       <= state_next;
            cmd_reg         <= cmd_next;
            idx_reg         <= idx_next;
            last_reg        <= last_next;
            repeat_reg      <= repeat_next;
            repeatValid_reg <= repeatValid_next;
            read_reg        <= read_next;
            readValid_reg   <= readValid_next;
            wiper_reg       <= wiper_next;
            latch_reg       <= latch_next;
            readPower_reg   <= readPower_next;
        end
    end

    assign wiperPos      = wiper_reg;
    assign latchedOutOne = latch_reg[LATCH_ONE_BIT];
    assign latchedOutTwo = latch_reg[LATCH_TWO_BIT];
    assign readPower     = readPower_reg;
    assign busy          = state_reg != ST_IDLE;

endmodule

// file: rtl/qwsd_link.sv
module qwsd_link
    import qwsd_pkg::*;
(
    input  wire logic       sclk,
    input  wire logic       rst,
    input  wire logic       csN,
    input  wire logic       serialIn,
    input  wire qwsd_word_s readWord,
    input  wire logic       readValid,
    output qwsd_word_s      frameWord,
    output logic            frameToggle,
    output logic            serialOut,
    output logic            serialOutOe
);

    logic       started_reg;
    logic [15:0] shift_reg;
    logic       toggle_reg;
    logic [15:0] effWord;

    // readback word replaces the shifter until the first edge of a frame
    assign effWord = (!started_reg && readValid) ? readWord : shift_reg;

    // chip select high clears the frame flag, so no edge is needed after a frame
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            shift_reg  <= '0;
            toggle_reg <= 1'b0;
        end else if (!csN) begin
            shift_reg <= {effWord[14:0], serialIn};
            if (!started_reg) begin
                toggle_reg <= !toggle_reg;
            end
        end
    end

    assign frameWord   = shift_reg;
    assign frameToggle = toggle_reg;
    assign serialOut   = 1'b0;
    assign serialOutOe = !csN && !effWord[15];

endmodule

// file: rtl/qwsd_nv_store.sv
module qwsd_nv_store
    import qwsd_pkg::*;
#(
    parameter int DEPTH = NV_DEPTH,
    parameter int WIDTH = NV_BITS
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic                     writeEn,
    input  wire logic [WIDTH-1:0]         writeData,
    output logic      [WIDTH-1:0]         readData
);

    initial begin
        if (DEPTH != NV_DEPTH || WIDTH != NV_BITS) begin
            $error("nv store must be 16 words of 8 bits");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // stored words sit in flops so reset restores the factory contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= qwsd_nv_init(i);
            end
        end else if (writeEn) begin
            mem_reg[addr] <= writeData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readData <= '0;
        end else begin
            readData <= mem_reg[addr];
        end
    end

endmodule

// file: tb/qwsd_decoder_monitor.sv
module qwsd_decoder_monitor
    import qwsd_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        csN,
    input wire logic                        serialOut,
    input wire logic                        serialOutOe,
    input wire logic [WIPER_COUNT-1:0][5:0] wiperPos,
    input wire logic                        latchedOutOne,
    input wire logic                        latchedOutTwo,
    input wire logic                        readPower,
    input wire logic                        busy
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // link and execution timing
    // ****************************************
    sequence s_frame_open;
        !csN [*6];
    endsequence

    a_oe_idle_release: assert property (csN |-> !serialOutOe)
        else $error("serial line pulled while deselected");
    a_drive_low_only: assert property (serialOut == 1'b0)
        else $error("serial line driven high");
    a_no_exec_in_frame: assert property (s_frame_open |-> !$rose(busy))
        else $error("execution started inside a frame");
    a_busy_bounded: assert property ($rose(busy) |-> ##[1:12] !busy)
        else $error("execution did not finish");
    a_wiper_exec_only: assert property ($changed(wiperPos) |-> $past(busy))
        else $error("wiper moved without execution");
    a_latch_exec_only: assert property (
        $changed({latchedOutOne, latchedOutTwo}) |-> $past(busy))
        else $error("latched output moved without execution");
    a_power_exec_only: assert property ($changed(readPower) |-> $past(busy))
        else $error("power state moved without execution");
    a_oe_stable_idle: assert property (csN ##1 csN |-> $stable(serialOutOe))
        else $error("serial line toggled while deselected");
endmodule

// file: tb/qwsd_host_model.sv
module qwsd_host_model (
    output logic      sclk,
    output logic      csN,
    output logic      serialIn,
    input  wire logic serialLine
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // mode 0 master, clock only inside frames
    // ****************************************
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        serialIn = 1'b1;
    end

    // line sampled just before each rise, while the device still holds its bit
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        #3.7 csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serialIn = tx[i];
            #6;
            rx = {rx[30:0], serialLine};
            sclk = 1'b1;
            #6;
            sclk = 1'b0;
        end
        #6 csN = 1'b1;
        serialIn = ~serialIn;
    endtask

    task automatic strobe();
        #3.7 csN = 1'b0;
        #12 csN = 1'b1;
    endtask
endmodule

// file: tb/tb_qwsd_decoder.sv
module tb_qwsd_decoder
    import qwsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        clk;
    logic                        rst;
    logic                        sclk;
    logic                        csN;
    logic                        serialIn;
    logic                        serialOut;
    logic                        serialOutOe;
    logic                        serialLine;
    logic [WIPER_COUNT-1:0][5:0] wiperPos;
    logic                        latchedOutOne;
    logic                        latchedOutTwo;
    logic                        readPower;
    logic                        busy;
    logic [31:0]                 rx;
    int                          errors = 0;
    int                          samplesChecked = 0;
    int                          cycles = 0;

    // external pull-up on the open-drain line
    assign serialLine = serialOutOe ? 1'b0 : 1'b1;

    qwsd_decoder qwsd_decoder_inst (
        .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutOe(serialOutOe), .wiperPos(wiperPos),
        .latchedOutOne(latchedOutOne), .latchedOutTwo(latchedOutTwo),
        .readPower(readPower), .busy(busy)
    );

    qwsd_host_model qwsd_host_model_inst (
        .sclk(sclk), .csN(csN), .serialIn(serialIn), .serialLine(serialLine)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("Error at %0t: run did not finish in time", $time);
            report_and_stop();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic report_and_stop();
        if (errors == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for completion, then keep chip select high long enough
    task automatic settle();
        int n;
        n = 0;
        repeat (6) @(negedge clk);
        while (busy !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(16'(busy), 16'h0000);
        repeat (12) @(negedge clk);
    endtask

    task automatic cmd(input logic [15:0] w);
        qwsd_host_model_inst.xfer({16'h0000, w}, 16, rx);
        settle();
    endtask

    function automatic logic [5:0] stepOp(input logic [3:0] op, input logic [5:0] v);
        case (op[3:1])
            3'h2: return v >> 1;
            3'h3: return (v == 6'h00) ? v : v - 6'h01;
            3'h6: return (v == 6'h00) ? 6'h01 : (v >= 6'h20) ? 6'h3F : v << 1;
            default: return (v == 6'h3F) ? v : v + 6'h01;
        endcase
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        static logic [5:0] w [4] = '{6'h00, 6'h01, 6'h20, 6'h3F};
        static logic [3:0] allOps [4] = '{4'hF, 4'h7, 4'hD, 4'h5};
        static logic [5:0] pre [9] = '{6'h3F, 6'h3E, 6'h00, 6'h05, 6'h00,
                                       6'h20, 6'h05, 6'h01, 6'h3F};
        static logic [3:0] op [9] = '{4'hE, 4'hE, 4'h6, 4'h6, 4'hC, 4'hC, 4'hC, 4'h4, 4'h4};
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        settle();
        for (int k = 0; k < 4; k++) chk(16'(wiperPos[k]), 16'h0020);
        chk(16'({latchedOutTwo, latchedOutOne, readPower}), 16'h0006);
        cmd(16'hB1D0);
        chk(16'(wiperPos[1]), 16'h0010);
        cmd(16'hA1FF);
        cmd(16'h0000);
        chk(rx[15:0], 16'hA110);
        qwsd_host_model_inst.xfer({16'h7F5A, 16'hB203}, 32, rx);
        settle();
        chk(rx[31:16], 16'h0000);
        chk(rx[15:0], 16'h7F5A);
        chk(16'({wiperPos[2], wiperPos[0]}), 16'h00E0);
        for (int i = 0; i < 9; i++) begin
            cmd({8'hB3, 2'b00, pre[i]});
            cmd({op[i], 4'h3, 8'hFF});
            chk(16'(wiperPos[3]), 16'(stepOp(op[i], pre[i])));
        end
        qwsd_host_model_inst.strobe();
        settle();
        chk(16'(wiperPos[3]), 16'h000F);
        cmd(16'hB305);
        qwsd_host_model_inst.strobe();
        settle();
        chk(16'(wiperPos[3]), 16'h0005);
        for (int k = 0; k < 4; k++) cmd({8'hB0 | 8'(k), 2'b00, w[k]});
        foreach (allOps[j]) begin
            cmd({allOps[j], 12'hFFF});
            for (int k = 0; k < 4; k++) begin
                w[k] = stepOp(allOps[j], w[k]);
                chk(16'(wiperPos[k]), 16'(w[k]));
            end
        end
        cmd(16'h0FFF);
        for (int k = 0; k < 4; k++) chk(16'(wiperPos[k]), 16'(w[k]));
        cmd(16'h35A5);
        cmd(16'h95FF);
        cmd(16'h0000);
        chk(rx[15:0], 16'h95A5);
        cmd(16'h2200);
        cmd(16'hB22A);
        cmd(16'h1200);
        chk(16'(wiperPos[2]), 16'(w[2]));
        chk(16'(readPower), 16'h0001);
        cmd(16'h0000);
        chk(16'(readPower), 16'h0000);
        cmd(16'hB011);
        cmd(16'h3402);
        chk(16'({latchedOutTwo, latchedOutOne}), 16'h0003);
        cmd(16'h8FFF);
        for (int k = 0; k < 4; k++) chk(16'(wiperPos[k]), (k == 2) ? 16'(w[2]) : 16'h0020);
        chk(16'({latchedOutTwo, latchedOutOne}), 16'h0002);
        report_and_stop();
    end
endmodule

bind qwsd_decoder qwsd_decoder_monitor qwsd_decoder_monitor_inst (
    .clk(clk), .rst(rst), .csN(csN), .serialOut(serialOut), .serialOutOe(serialOutOe),
    .wiperPos(wiperPos), .latchedOutOne(latchedOutOne), .latchedOutTwo(latchedOutTwo),
    .readPower(readPower), .busy(busy)
);
